// *** rtl/fcs_map.svh ***
// Constants of the flash command sequencer: command bytes, status bits,
// bus timing and widths. Assumes a 20 ns reference clock.
//
// ---------------------------------------------------------------------
// Rules
// ---------------------------------------------------------------------
// Overview of operation
// RQ1: Device decodes each command, picks next state
// RQ2: After C0H, next write is protection data
// RQ3: Suspended config/query reads go to suspended variants
// RQ4: Host writes B0H anywhere to suspend programming
// RQ5: Host then writes 70H to read status
// RQ6: Toggle chip or output enable between polls
// RQ7: Ready flag high means machine ready; poll it
// RQ8: Suspended flag tells suspended versus already complete
// RQ9: During suspend, read only other blocks' array
// RQ10: Host writes D0H anywhere to resume
// RQ11: Query command switches reads to query database
// RQ12: Bad confirm after setup gives command error; the model drops it with no error bit and the host reports none
// RQ13: Erase suspend accepts lock setup, D0H resumes
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH

// ---------------------------------------------------------------------
// Widths
// ---------------------------------------------------------------------
`define FCS_ADDR_W 22
`define FCS_DATA_W 16
`define FCS_BLK_LSB 15

// ---------------------------------------------------------------------
// Command bytes
// ---------------------------------------------------------------------
`define FCS_CMD_READ_ARRAY 16'h00FF
`define FCS_CMD_PROGRAM 16'h0040
`define FCS_CMD_ERASE 16'h0020
`define FCS_CMD_SUSPEND 16'h00B0
`define FCS_CMD_RESUME 16'h00D0
`define FCS_CMD_STATUS 16'h0070
`define FCS_CMD_CONFIG 16'h0090
`define FCS_CMD_QUERY 16'h0098
`define FCS_CMD_LOCK_SETUP 16'h0060
`define FCS_CMD_PROT_SETUP 16'h00C0

// ---------------------------------------------------------------------
// Status bits
// ---------------------------------------------------------------------
`define FCS_SR_READY 7
`define FCS_SR_PSUSP 2

// ---------------------------------------------------------------------
// Bus timing, ns and derived cycles (least times round up)
// ---------------------------------------------------------------------
`define FCS_CLK_NS 20
`define FCS_T_WP_NS 60
`define FCS_T_ACC_NS 100
`define FCS_T_GAP_NS 40
`define FCS_WP_CYC ((`FCS_T_WP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_ACC_CYC ((`FCS_T_ACC_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_GAP_CYC ((`FCS_T_GAP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)

`endif

// *** rtl/fcs_pkg.sv ***
// Types of the flash command sequencer: operations, states, carriers.
// Assumes fcs_map.svh is on the include path.
`include "fcs_map.svh"

package fcs_pkg;

  // Operations the user may request
  typedef enum logic [3:0] {
    FCS_OP_WRITE, FCS_OP_READ, FCS_OP_ARRAY, FCS_OP_QUERY, FCS_OP_CONFIG,
    FCS_OP_PROGRAM, FCS_OP_ERASE, FCS_OP_LOCK, FCS_OP_PROTECT,
    FCS_OP_SUSPEND, FCS_OP_STATUS, FCS_OP_RESUME
  } fcs_op_t;

  // Bus engine states
  typedef enum logic [2:0] {
    FCS_S_IDLE, FCS_S_NEXT, FCS_S_WR_SETUP, FCS_S_WR_PULSE, FCS_S_WR_HOLD,
    FCS_S_RD_ACC, FCS_S_RD_GAP
  } fcs_state_t;

  // User request
  typedef struct packed {
    fcs_op_t op;
    logic [`FCS_ADDR_W-1:0] addr;
    logic [`FCS_DATA_W-1:0] data;
  } fcs_req_t;

  // User response
  typedef struct packed {
    logic valid;
    logic err;
    logic suspended;
    logic [`FCS_DATA_W-1:0] data;
  } fcs_rsp_t;

  // Flash pin outputs
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic [`FCS_ADDR_W-1:0] addr;
    logic [`FCS_DATA_W-1:0] dq_out;
  } fcs_pins_t;

  // Whole state of the sequencer
  typedef struct packed {
    fcs_state_t st;
    fcs_op_t op;
    logic [1:0] step;
    logic [3:0] cnt;
    logic [`FCS_ADDR_W-1:0] uaddr;
    logic [`FCS_DATA_W-1:0] udata;
    logic [`FCS_DATA_W-1:0] rdata;
    logic susp;
    logic [`FCS_ADDR_W-`FCS_BLK_LSB-1:0] prog_blk;
    logic req_ready;
    fcs_rsp_t rsp;
    fcs_pins_t pins;
  } fcs_regs_t;

endpackage

// *** rtl/fcs_host.sv ***
// Host-side sequencer that drives an asynchronous parallel NOR flash
// through its chip, output and write enables and data pins.
// Assumes the flash answers within the access time in fcs_map.svh and
// that dq_in is already synchronous to ref_clk.
`timescale 1ns/100ps
`include "fcs_map.svh"

module fcs_host
  import fcs_pkg::*;
(
  input wire logic ref_clk,             // 50 MHz clock
  input wire logic reset,               // Synchronous, active high
  input wire logic req_valid,           // Request present
  input fcs_req_t req,                  // Operation, address, data
  output logic req_ready,               // Idle, request may be taken
  output fcs_rsp_t rsp,                 // One-cycle answer
  output fcs_pins_t pins,               // Flash pins driven
  input wire logic [`FCS_DATA_W-1:0] dq_in // Flash data read back
);

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  fcs_regs_t s_r;   // All registered state
  fcs_regs_t s_nxt; // Next value

  logic go_wr;                      // Start a write cycle
  logic go_rd;                      // Start a read cycle
  logic fin;                        // Operation complete
  logic poll;                       // Status polling stage
  logic [`FCS_ADDR_W-1:0] cyc_addr; // Address of next cycle
  logic [`FCS_DATA_W-1:0] cyc_data; // Data of next write
  logic blocked;                    // Array read of suspended block

  // First command byte of each operation
  function automatic logic [`FCS_DATA_W-1:0] first_cmd(input fcs_op_t op);
    case (op)
      FCS_OP_ARRAY: first_cmd = `FCS_CMD_READ_ARRAY;
      FCS_OP_QUERY: first_cmd = `FCS_CMD_QUERY;
      FCS_OP_CONFIG: first_cmd = `FCS_CMD_CONFIG;
      FCS_OP_PROGRAM: first_cmd = `FCS_CMD_PROGRAM;
      FCS_OP_ERASE: first_cmd = `FCS_CMD_ERASE;
      FCS_OP_LOCK: first_cmd = `FCS_CMD_LOCK_SETUP;
      FCS_OP_PROTECT: first_cmd = `FCS_CMD_PROT_SETUP;
      FCS_OP_SUSPEND: first_cmd = `FCS_CMD_SUSPEND;
      FCS_OP_STATUS: first_cmd = `FCS_CMD_STATUS;
      FCS_OP_RESUME: first_cmd = `FCS_CMD_RESUME;
      default: first_cmd = `FCS_CMD_READ_ARRAY;
    endcase
  endfunction

  // -------------------------------------------------------------------
  // Sequencing of bus cycles per operation
  // -------------------------------------------------------------------
  always_comb
  begin
    go_wr = 1'b0;
    go_rd = 1'b0;
    fin = 1'b0;
    cyc_addr = s_r.uaddr;
    cyc_data = s_r.udata;
    // Polling of the ready flag after a status command or after the protection data write
    poll = (s_r.op == FCS_OP_STATUS && s_r.step == 2'd2) ||
           ((s_r.op == FCS_OP_SUSPEND || s_r.op == FCS_OP_PROTECT) &&
            s_r.step == 2'd3);
    if (poll)
    begin
      // Only trust other bits once ready reads one
      if (s_r.rdata[`FCS_SR_READY]) // RQ7
        fin = 1'b1;
      else
        go_rd = 1'b1; // RQ6
    end
    else if (s_r.step == 2'd0)
    begin
      // Plain write, plain read, or the leading command byte
      if (s_r.op == FCS_OP_WRITE)
        go_wr = 1'b1;
      else if (s_r.op == FCS_OP_READ)
        go_rd = 1'b1;
      else
      begin
        go_wr = 1'b1;
        cyc_data = first_cmd(s_r.op); // RQ1 RQ4 RQ10 RQ11
      end
    end
    else if (s_r.step == 2'd1)
    begin
      case (s_r.op)
        FCS_OP_SUSPEND:
        begin
          go_wr = 1'b1;
          cyc_data = `FCS_CMD_STATUS; // RQ5
        end
        // Second write carries data or confirm byte
        FCS_OP_PROGRAM, FCS_OP_ERASE, FCS_OP_LOCK, FCS_OP_PROTECT:
          go_wr = 1'b1; // RQ2 RQ12
        FCS_OP_ARRAY, FCS_OP_QUERY, FCS_OP_CONFIG, FCS_OP_STATUS:
          go_rd = 1'b1; // RQ9 RQ11
        default:
          fin = 1'b1;
      endcase
    end
    else
    begin
      // Step two: status reads for suspend and protect, else done
      if (s_r.op == FCS_OP_SUSPEND || s_r.op == FCS_OP_PROTECT)
        go_rd = 1'b1; // RQ2 RQ5
      else
        fin = 1'b1;
    end
    if (s_r.step == 2'd0 || go_rd)
      cyc_addr = s_r.uaddr;
  end

  // Array reads of the block whose program is suspended are refused
  assign blocked = req.op == FCS_OP_ARRAY && s_r.susp &&
                   req.addr[`FCS_ADDR_W-1:`FCS_BLK_LSB] == s_r.prog_blk; // RQ9

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rsp.valid = 1'b0;
    s_nxt.rsp.err = 1'b0;
    case (s_r.st)
      FCS_S_IDLE:
      begin
        if (req_valid)
        begin
          if (blocked)
          begin
            // Refused at once, no bus cycle
            s_nxt.rsp.valid = 1'b1;
            s_nxt.rsp.err = 1'b1;
          end
          else
          begin
            s_nxt.op = req.op;
            s_nxt.uaddr = req.addr;
            s_nxt.udata = req.data;
            s_nxt.step = 2'd0;
            s_nxt.st = FCS_S_NEXT;
            if (req.op == FCS_OP_PROGRAM)
              s_nxt.prog_blk = req.addr[`FCS_ADDR_W-1:`FCS_BLK_LSB];
          end
        end
      end
      FCS_S_NEXT:
      begin
        if (fin)
        begin
          s_nxt.st = FCS_S_IDLE;
          s_nxt.rsp.valid = 1'b1;
          s_nxt.rsp.data = s_r.rdata;
          // Suspended only if the flash says so, else program finished
          if (s_r.op == FCS_OP_SUSPEND)
            s_nxt.susp = s_r.rdata[`FCS_SR_PSUSP]; // RQ8
          else if (s_r.op == FCS_OP_RESUME)
            s_nxt.susp = 1'b0; // RQ10
          s_nxt.rsp.suspended = s_nxt.susp;
        end
        else
        begin
          s_nxt.pins.addr = cyc_addr;
          s_nxt.pins.dq_out = cyc_data;
          if (!poll)
            s_nxt.step = s_r.step + 2'd1;
          if (go_wr)
            s_nxt.st = FCS_S_WR_SETUP;
          else
          begin
            s_nxt.st = FCS_S_RD_ACC;
            s_nxt.cnt = 4'(`FCS_ACC_CYC - 1);
          end
        end
      end
      FCS_S_WR_SETUP:
      begin
        s_nxt.st = FCS_S_WR_PULSE;
        s_nxt.cnt = 4'(`FCS_WP_CYC - 1);
      end
      FCS_S_WR_PULSE:
      begin
        if (s_r.cnt == 4'h0)
          s_nxt.st = FCS_S_WR_HOLD;
        else
          s_nxt.cnt = s_r.cnt - 4'h1;
      end
      FCS_S_WR_HOLD:
        s_nxt.st = FCS_S_NEXT;
      FCS_S_RD_ACC:
      begin
        // Sample at end of access; each poll is a fresh read cycle
        if (s_r.cnt == 4'h0)
        begin
          s_nxt.rdata = dq_in;
          s_nxt.st = FCS_S_RD_GAP; // RQ6
          s_nxt.cnt = 4'(`FCS_GAP_CYC - 1);
        end
        else
          s_nxt.cnt = s_r.cnt - 4'h1;
      end
      FCS_S_RD_GAP:
      begin
        if (s_r.cnt == 4'h0)
          s_nxt.st = FCS_S_NEXT;
        else
          s_nxt.cnt = s_r.cnt - 4'h1;
      end
      default:
        s_nxt.st = FCS_S_IDLE;
    endcase
    // Pins follow the next state so they leave flip-flops directly
    s_nxt.pins.ce_n = !(s_nxt.st inside {FCS_S_WR_SETUP, FCS_S_WR_PULSE,
                                         FCS_S_RD_ACC});
    s_nxt.pins.we_n = !(s_nxt.st == FCS_S_WR_PULSE);
    s_nxt.pins.oe_n = !(s_nxt.st == FCS_S_RD_ACC); // RQ6
    s_nxt.pins.dq_oe = s_nxt.st inside {FCS_S_WR_SETUP, FCS_S_WR_PULSE,
                                        FCS_S_WR_HOLD};
    s_nxt.req_ready = s_nxt.st == FCS_S_IDLE;
  end

  // -------------------------------------------------------------------
  // Register
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_r <= '0;
      s_r.st <= FCS_S_IDLE;
      s_r.op <= FCS_OP_WRITE;
      s_r.req_ready <= 1'b1;
      s_r.pins.ce_n <= 1'b1;
      s_r.pins.oe_n <= 1'b1;
      s_r.pins.we_n <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign req_ready = s_r.req_ready;
  assign rsp = s_r.rsp;
  assign pins = s_r.pins;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  suspend_cmd_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ4
    ($fell(pins.we_n) && s_r.op == FCS_OP_SUSPEND && s_r.step == 2'd1)
      |-> pins.dq_out == `FCS_CMD_SUSPEND && pins.dq_oe)
    else $error("suspend write not B0");

  status_cmd_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ5
    ($fell(pins.we_n) && s_r.op == FCS_OP_SUSPEND && s_r.step == 2'd2)
      |-> pins.dq_out == `FCS_CMD_STATUS)
    else $error("status command not 70 after suspend");

  // Repetition counts are written out: 2 is the gap count, 3 the pulse count
  oe_toggle_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ6
    $rose(pins.oe_n) |-> pins.oe_n [*2])
    else $error("output enable not held high between polls");

  ready_poll_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ7
    (rsp.valid && !rsp.err && (s_r.op == FCS_OP_STATUS ||
     s_r.op == FCS_OP_SUSPEND)) |-> rsp.data[`FCS_SR_READY])
    else $error("status answered before ready");

  susp_flag_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ8
    (rsp.valid && s_r.op == FCS_OP_SUSPEND && !rsp.err)
      |-> rsp.suspended == rsp.data[`FCS_SR_PSUSP])
    else $error("suspended flag mismatch");

  other_blk_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ9
    (req_valid && req_ready && blocked) |=> rsp.valid && rsp.err && req_ready)
    else $error("suspended block read not refused");

  resume_cmd_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ10
    ($fell(pins.we_n) && s_r.op == FCS_OP_RESUME)
      |-> pins.dq_out == `FCS_CMD_RESUME)
    else $error("resume write not D0");

  query_cmd_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ11
    ($fell(pins.we_n) && s_r.op == FCS_OP_QUERY && s_r.step == 2'd1)
      |-> pins.dq_out == `FCS_CMD_QUERY)
    else $error("query command not 98");

  pulse_len_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ1
    $fell(pins.we_n) |-> !pins.we_n [*3] ##1 pins.we_n && pins.dq_oe)
    else $error("write pulse length wrong");

  prot_data_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ2
    ($fell(pins.we_n) && s_r.op == FCS_OP_PROTECT && s_r.step == 2'd2)
      |-> pins.dq_out == s_r.udata)
    else $error("protection data write wrong");

  suspended_c: cover property (@(posedge ref_clk) disable iff (reset)
    rsp.valid && s_r.op == FCS_OP_SUSPEND && rsp.suspended);
  completed_c: cover property (@(posedge ref_clk) disable iff (reset)
    rsp.valid && s_r.op == FCS_OP_SUSPEND && !rsp.suspended);
  query_c: cover property (@(posedge ref_clk) disable iff (reset)
    rsp.valid && s_r.op == FCS_OP_QUERY);
  resume_c: cover property (@(posedge ref_clk) disable iff (reset)
    rsp.valid && s_r.op == FCS_OP_RESUME);

endmodule

// *** testbench/fcs_flash_model.sv ***
// Behavioural flash seen through the sequencer's pins: commands, status, query.
// Assumes pins change on ref_clk edges; busy time is counted in read cycles.
`timescale 1ns/100ps
`include "fcs_map.svh"

module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter int PROG_POLLS = 3,              // Reads until a program ends
  parameter logic [15:0] CFG_WORD = 16'h00A7 // Arbitrary configuration word
)
(
  input fcs_pins_t pins,                     // Pins from the sequencer
  output logic [`FCS_DATA_W-1:0] dq_in       // Data back to the sequencer
);
  // ---------------------------------------------------------------
  // Command state
  // ---------------------------------------------------------------
  logic [1:0] mode = 2'h0;         // 0 array, 1 status, 2 config, 3 query
  logic [1:0] pend = 2'h0;         // 1 program, 2 erase, 3 lock, 0 none
  logic prot_pend = 1'b0;          // Protection data expected
  logic psus = 1'b0;               // Program suspended
  logic esus = 1'b0;               // Erase suspended
  int prog_left = 0;               // Busy reads left
  int erase_left = 0;
  int prot_left = 0;
  int susp_wait = 0;
  logic [15:0] out_val = 16'h0000; // Word of the current read
  logic [7:0] d;
  wire wr_act = !pins.we_n && !pins.ce_n;
  wire rd_act = !pins.ce_n && !pins.oe_n;
  wire ready = susp_wait == 0 && prot_left == 0 && (prog_left == 0 || psus)
               && (erase_left == 0 || esus);

  // ---------------------------------------------------------------
  // Command taken as the write pulse ends, enables rise together
  // ---------------------------------------------------------------
  always @(negedge wr_act)
  begin
    d = pins.dq_out[7:0];
    if (prot_left > 0 || (d != 8'hB0 && ((prog_left > 0 && !psus) || (erase_left > 0 && !esus))))
      mode = 2'h1; // Busy, command dropped
    else if (prot_pend || pend != 2'h0)
    begin
      prot_left = prot_pend ? PROG_POLLS : prot_left;
      prog_left = (pend == 2'h1) ? PROG_POLLS : prog_left;
      erase_left = (pend == 2'h2 && d == 8'hD0) ? PROG_POLLS + 1 : erase_left;
      pend = 2'h0;
      prot_pend = 1'b0;
      mode = 2'h1;
    end
    else
      case (d)
        8'hFF: mode = 2'h0;
        8'h70: mode = 2'h1;
        8'h90: mode = 2'h2;
        8'h98: mode = 2'h3;
        8'h10, 8'h40: pend = psus ? 2'h0 : 2'h1;
        8'h20: pend = (psus || esus) ? 2'h0 : 2'h2;
        8'h60: {pend, mode} = psus ? 4'h0 : 4'hD;
        8'hC0: {prot_pend, mode} = (psus || esus) ? 3'h0 : 3'h5;
        8'hD0: {psus, esus, mode} = (psus || esus) ? 4'h1 : 4'h0;
        8'hB0:
        begin
          psus = psus || prog_left > 0;
          esus = esus || (erase_left > 0 && !psus);
          susp_wait = (psus || esus) ? 1 : 0;
          mode = (psus || esus) ? 2'h1 : 2'h0;
        end
        default: mode = 2'h0;
      endcase
  end

  // ---------------------------------------------------------------
  // Word fixed at each read start: stale status until a new read
  // ---------------------------------------------------------------
  always @(posedge rd_act)
  begin
    case (mode)
      2'h0: out_val = pins.addr[15:0] ^ 16'h5555;
      2'h1: out_val = {8'h00, ready, 4'h0, psus, 2'h0};
      2'h2: out_val = CFG_WORD;
      default: out_val = (pins.addr == 22'h0010) ? 16'h0051 :
                         (pins.addr == 22'h0011) ? 16'h0052 :
                         (pins.addr == 22'h0012) ? 16'h0059 : 16'h0000;
    endcase
    susp_wait -= (susp_wait > 0) ? 1 : 0;
    prot_left -= (prot_left > 0) ? 1 : 0;
    prog_left -= (prog_left > 0 && !psus) ? 1 : 0;
    erase_left -= (erase_left > 0 && !esus) ? 1 : 0;
  end

  // Released bus shows the inverse, never a lucky stale match
  assign dq_in = rd_act ? out_val : ~out_val;
endmodule

// *** testbench/fcs_host_tb.sv ***
// Self-checking bench of the flash command sequencer with a flash model.
// Assumes the rtl files and fcs_flash_model are compiled first.
`timescale 1ns/100ps
`include "fcs_map.svh"

module fcs_host_tb
  import fcs_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals and expectations
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] data; // Expected word
    logic chk;         // Word is compared
    logic err;         // Refusal expected
    logic susp;        // Suspend flag expected
  } fcs_exp_t;
  localparam logic [15:0] CFG_WORD = 16'h00A7; // Arbitrary
  localparam logic [15:0] NONE = 16'h0000;
  logic ref_clk, reset, req_valid, req_ready;
  fcs_req_t req;
  fcs_rsp_t rsp;
  fcs_pins_t pins;
  logic [`FCS_DATA_W-1:0] dq_in;
  logic [21:0] pa, oa; // Programmed and other block
  logic [15:0] pd;
  fcs_exp_t exp_q[$];
  int miscompares = 0;
  int n_tests = 0;

  fcs_host i_dut (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp(rsp), .pins(pins), .dq_in(dq_in));
  fcs_flash_model #(.PROG_POLLS(3), .CFG_WORD(CFG_WORD)) i_flash (.pins(pins), .dq_in(dq_in));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Bounded wait used up or answer with no note: counted, then the run closes
  task automatic hang(string s);
    miscompares++;
    $display("MISMATCH at %0t: no %s", $time, s);
    summarize();
  endtask

  task automatic cmp_rsp(fcs_exp_t e, fcs_rsp_t r);
    n_tests++;
    if (r.err !== e.err || r.suspended !== e.susp || (e.chk && r.data !== e.data))
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h %b %b want %h %b %b", $time, r.data, r.err,
               r.suspended, e.data, e.err, e.susp);
    end
  endtask

  // One request: note the expectation, hold until taken, await the answer
  task automatic do_op(fcs_op_t op, logic [21:0] a, logic [15:0] dat, logic [15:0] xd,
                       logic chk, logic xe, logic xs);
    int n;
    exp_q.push_back(fcs_exp_t'{xd, chk, xe, xs});
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= fcs_req_t'{op, a, dat};
    n = 0;
    // Ready judged mid-cycle, away from the edge that updates it
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 100);
    if (req_ready !== 1'b1)
      hang("ready");
    @(posedge ref_clk);
    req_valid <= 1'b0;
    while (exp_q.size() != 0 && n < 3000)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000)
      hang("answer");
  endtask

  // ---------------------------------------------------------------
  // Clock, answer monitor, main sequence
  // ---------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Answers are taken against the oldest note, mid-cycle where settled
  always @(negedge ref_clk)
  begin
    if (rsp.valid === 1'b1 && exp_q.size() == 0)
      hang("request for an answer");
    else if (rsp.valid === 1'b1)
      cmp_rsp(exp_q.pop_front(), rsp);
  end

  initial
  begin
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    void'($urandom(32'ha589_8875));
    pa = 22'($urandom);
    pd = 16'($urandom);
    oa = {pa[21:15] ^ 7'h01, 15'($urandom)};
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    do_op(FCS_OP_QUERY, 22'h0010, NONE, 16'h0051, 1'b1, 1'b0, 1'b0);
    do_op(FCS_OP_QUERY, 22'h0012, NONE, 16'h0059, 1'b1, 1'b0, 1'b0);
    do_op(FCS_OP_CONFIG, pa, NONE, CFG_WORD, 1'b1, 1'b0, 1'b0);
    do_op(FCS_OP_WRITE, oa, 16'h00FF, NONE, 1'b0, 1'b0, 1'b0);
    do_op(FCS_OP_READ, oa, NONE, oa[15:0] ^ 16'h5555, 1'b1, 1'b0, 1'b0);
    $display("Test reads done");
    do_op(FCS_OP_PROGRAM, pa, pd, NONE, 1'b0, 1'b0, 1'b0);
    do_op(FCS_OP_SUSPEND, pa, NONE, 16'h0084, 1'b1, 1'b0, 1'b1);
    do_op(FCS_OP_ARRAY, pa, NONE, NONE, 1'b0, 1'b1, 1'b1);
    do_op(FCS_OP_ARRAY, oa, NONE, oa[15:0] ^ 16'h5555, 1'b1, 1'b0, 1'b1);
    do_op(FCS_OP_QUERY, 22'h0011, NONE, 16'h0052, 1'b1, 1'b0, 1'b1);
    do_op(FCS_OP_RESUME, oa, NONE, NONE, 1'b0, 1'b0, 1'b0);
    do_op(FCS_OP_STATUS, oa, NONE, 16'h0080, 1'b1, 1'b0, 1'b0);
    $display("Test suspend done");
    do_op(FCS_OP_PROGRAM, oa, pd, NONE, 1'b0, 1'b0, 1'b0);
    do_op(FCS_OP_STATUS, oa, NONE, 16'h0080, 1'b1, 1'b0, 1'b0);
    do_op(FCS_OP_SUSPEND, oa, NONE, 16'h0080, 1'b1, 1'b0, 1'b0);
    do_op(FCS_OP_PROTECT, pa, pd, 16'h0080, 1'b1, 1'b0, 1'b0);
    $display("Test late suspend done");
    do_op(FCS_OP_LOCK, pa, 16'h0001, NONE, 1'b0, 1'b0, 1'b0);
    do_op(FCS_OP_LOCK, pa, 16'h00FF, NONE, 1'b0, 1'b0, 1'b0);
    do_op(FCS_OP_ERASE, pa, 16'h00D0, NONE, 1'b0, 1'b0, 1'b0);
    do_op(FCS_OP_SUSPEND, pa, NONE, 16'h0080, 1'b1, 1'b0, 1'b0);
    do_op(FCS_OP_LOCK, oa, 16'h0001, NONE, 1'b0, 1'b0, 1'b0);
    do_op(FCS_OP_RESUME, oa, NONE, NONE, 1'b0, 1'b0, 1'b0);
    do_op(FCS_OP_STATUS, oa, NONE, 16'h0080, 1'b1, 1'b0, 1'b0);
    $display("Test erase done");
    summarize();
  end
endmodule
